// ===== rtl/iaep_defines.vh
`ifndef IAEP_DEFINES_VH
`define IAEP_DEFINES_VH

// ---------------------------------------------------------------
// Register map
// ---------------------------------------------------------------
`define IAEP_ADDR_W 4
`define IAEP_DATA_W 32
`define IAEP_REG_ARM 4'h0
`define IAEP_REG_ENABLE 4'h1
`define IAEP_REG_PEND_CLR 4'h2
`define IAEP_REG_LEVEL 4'h3
`define IAEP_REG_POLARITY 4'h4
`define IAEP_REG_DIST_EN 4'h5
`define IAEP_REG_REQUEST 4'h6
`define IAEP_REG_PENDING 4'h7
`define IAEP_REG_STATUS 4'h8
`define IAEP_REG_DIST_SEL0 4'h9
`define IAEP_REG_DIST_SEL1 4'hA
`define IAEP_REG_RAW 4'hB

// ---------------------------------------------------------------
// Line counts and fields
// ---------------------------------------------------------------
`define IAEP_NUM_EXT 12
`define IAEP_NUM_CHAIN 8
`define IAEP_NUM_LINES 20
`define IAEP_LINE_W 5
`define IAEP_CHAIN_SEL_W 3
`define IAEP_STAT_VALID_BIT 8

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define IAEP_CLK_HZ 20000000
`define IAEP_MIN_HOLD_NS 1500

`endif

// ===== rtl/iaep_recognizer.v
`timescale 1ns/1ps
`include "iaep_defines.vh"

module iaep_recognizer #(
   parameter N = `IAEP_NUM_LINES
) (
   // Clock and reset
   input wire clock,
   input wire rstn,
   // Synchronized line levels and configuration
   input wire [N-1:0] line_in,
   input wire [N-1:0] level_mode,
   input wire [N-1:0] active_high,
   // Recognized requests, one cycle per event in edge mode
   output wire [N-1:0] req_pulse
);

   reg [N-1:0] active_prev_q;
   wire [N-1:0] active;

   // Polarity folds into one active term: rising/high vs falling/low.
   assign active = ~(line_in ^ active_high);

   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         active_prev_q <= {N{1'b0}};
      end else begin
         active_prev_q <= active;
      end
   end

   // Edge mode fires once per inactive-to-active change; level mode requests while active.
   assign req_pulse = (level_mode & active) | (~level_mode & active & ~active_prev_q);

endmodule

// ===== rtl/iaep_priority.v
`timescale 1ns/1ps
`include "iaep_defines.vh"

module iaep_priority #(
   parameter N = `IAEP_NUM_LINES,
   parameter W = `IAEP_LINE_W
) (
   // Candidate requests
   input wire [N-1:0] cand,
   // Winner
   output reg found,
   output reg [W-1:0] index
);

   integer i;

   always @* begin
      found = 1'b0;
      index = {W{1'b0}};
      for (i = N - 1; i >= 0; i = i - 1) begin
         if (cand[i]) begin
            found = 1'b1;
            index = i[W-1:0];
         end
      end
   end

endmodule

// ===== rtl/iaep_top.v
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "iaep_defines.vh"

module iaep_top #(
   parameter NUM_EXT = `IAEP_NUM_EXT,
   parameter NUM_CHAIN = `IAEP_NUM_CHAIN
) (
   // Clock and reset
   input wire clock,
   input wire rstn,
   // Register port
   input wire [`IAEP_ADDR_W-1:0] reg_addr,
   input wire [`IAEP_DATA_W-1:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [`IAEP_DATA_W-1:0] reg_rdata,
   // External interrupt inputs
   input wire [NUM_EXT-1:0] ext_irq_in,
   // Chain interrupt lines, input from peers and output toward peers
   input wire [NUM_CHAIN-1:0] chain_shared_interrupt_in,
   output reg [NUM_CHAIN-1:0] chain_shared_interrupt_out,
   output reg [NUM_CHAIN-1:0] chain_shared_interrupt_oe,
   // Host interrupt request
   output reg host_irq,
   output reg [`IAEP_LINE_W-1:0] host_irq_line
);

   localparam N = NUM_EXT + NUM_CHAIN;

   // ---------------------------------------------------------------
   // Input synchronizers
   // ---------------------------------------------------------------
   reg [NUM_EXT-1:0] ext_s1_q;
   reg [NUM_EXT-1:0] ext_s2_q;
   reg [NUM_CHAIN-1:0] chn_s1_q;
   reg [NUM_CHAIN-1:0] chn_s2_q;

   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         ext_s1_q <= {NUM_EXT{1'b0}};
         ext_s2_q <= {NUM_EXT{1'b0}};
         chn_s1_q <= {NUM_CHAIN{1'b0}};
         chn_s2_q <= {NUM_CHAIN{1'b0}};
      end else begin
         ext_s1_q <= ext_irq_in;
         ext_s2_q <= ext_s1_q;
         chn_s1_q <= chain_shared_interrupt_in;
         chn_s2_q <= chn_s1_q;
      end
   end

   // ---------------------------------------------------------------
   // Configuration and state registers
   // ---------------------------------------------------------------
   reg [N-1:0] arm_q;
   reg [N-1:0] enable_q;
   reg [N-1:0] level_q;
   reg [N-1:0] polarity_q;
   reg [NUM_EXT-1:0] dist_en_q;
   reg [NUM_EXT*`IAEP_CHAIN_SEL_W-1:0] dist_sel_q;
   reg [N-1:0] request_q;
   reg [N-1:0] request_d;
   reg [N-1:0] pending_q;
   reg [N-1:0] pending_d;
   reg [NUM_CHAIN-1:0] chain_out_d;
   reg [NUM_CHAIN-1:0] chain_oe_d;

   wire [N-1:0] line_level;
   wire [N-1:0] req_pulse;
   wire [N-1:0] cand;
   wire grant_found;
   wire [`IAEP_LINE_W-1:0] grant_idx;
   wire wr_arm;
   wire wr_enable;
   wire wr_pclr;

   assign line_level = {chn_s2_q, ext_s2_q};

   function [N-1:0] low_bits;
      input [`IAEP_DATA_W-1:0] d;
      begin
         low_bits = d[N-1:0];
      end
   endfunction

   function [`IAEP_DATA_W-1:0] rd_pad;
      input [N-1:0] v;
      begin
         rd_pad = {{(`IAEP_DATA_W-N){1'b0}}, v};
      end
   endfunction

   function [`IAEP_CHAIN_SEL_W-1:0] sel_of;
      input [NUM_EXT*`IAEP_CHAIN_SEL_W-1:0] s;
      input integer k;
      begin
         sel_of = s[k*`IAEP_CHAIN_SEL_W +: `IAEP_CHAIN_SEL_W];
      end
   endfunction

   assign wr_arm = reg_wr && (reg_addr == `IAEP_REG_ARM);
   assign wr_enable = reg_wr && (reg_addr == `IAEP_REG_ENABLE);
   assign wr_pclr = reg_wr && (reg_addr == `IAEP_REG_PEND_CLR);

   // ---------------------------------------------------------------
   // Request recognition and priority
   // ---------------------------------------------------------------
   iaep_recognizer #(
      .N(N)
   ) u_rec (
      .clock(clock),
      .rstn(rstn),
      .line_in(line_level),
      .level_mode(level_q),
      .active_high(polarity_q),
      .req_pulse(req_pulse)
   );

   // Only armed, enabled lines with a held request and no pending service compete.
   assign cand = request_q & arm_q & enable_q & ~pending_q;

   iaep_priority #(
      .N(N),
      .W(`IAEP_LINE_W)
   ) u_pri (
      .cand(cand),
      .found(grant_found),
      .index(grant_idx)
   );

   // ---------------------------------------------------------------
   // Request and pending update
   // ---------------------------------------------------------------
   integer j;

   always @* begin
      request_d = (request_q | req_pulse) & arm_q;
      pending_d = pending_q;
      if (wr_pclr) begin
         pending_d = pending_q & ~low_bits(reg_wdata);
      end
      // A single grant per cycle; a fresh delivery wins over a same-cycle clear.
      // A request recognized in the grant cycle itself is kept, so no event is lost.
      if (grant_found && !host_irq) begin
         request_d[grant_idx] = req_pulse[grant_idx] & arm_q[grant_idx];
         pending_d[grant_idx] = 1'b1;
      end
      // An arm write that clears a bit takes effect on the next cycle's request.
      if (wr_arm) begin
         request_d = request_d & low_bits(reg_wdata);
      end
   end

   // ---------------------------------------------------------------
   // Chain distribution
   // ---------------------------------------------------------------
   always @* begin
      chain_out_d = {NUM_CHAIN{1'b0}};
      chain_oe_d = {NUM_CHAIN{1'b0}};
      for (j = 0; j < NUM_EXT; j = j + 1) begin
         if (dist_en_q[j]) begin
            // Raw line level feeds the chain, without the local arm and enable gating.
            chain_oe_d[sel_of(dist_sel_q, j)] = 1'b1;
            chain_out_d[sel_of(dist_sel_q, j)] = chain_out_d[sel_of(dist_sel_q, j)] | ext_s2_q[j];
         end
      end
   end

   // ---------------------------------------------------------------
   // Sequential state
   // ---------------------------------------------------------------
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         arm_q <= {N{1'b0}};
         enable_q <= {N{1'b0}};
         level_q <= {N{1'b0}};
         polarity_q <= {N{1'b1}};
         dist_en_q <= {NUM_EXT{1'b0}};
         dist_sel_q <= {(NUM_EXT*`IAEP_CHAIN_SEL_W){1'b0}};
         request_q <= {N{1'b0}};
         pending_q <= {N{1'b0}};
         host_irq <= 1'b0;
         host_irq_line <= {`IAEP_LINE_W{1'b0}};
         chain_shared_interrupt_out <= {NUM_CHAIN{1'b0}};
         chain_shared_interrupt_oe <= {NUM_CHAIN{1'b0}};
      end else begin
         if (wr_arm) begin
            arm_q <= low_bits(reg_wdata);
         end
         if (wr_enable) begin
            enable_q <= low_bits(reg_wdata);
         end
         if (reg_wr && (reg_addr == `IAEP_REG_LEVEL)) begin
            level_q <= low_bits(reg_wdata);
         end
         if (reg_wr && (reg_addr == `IAEP_REG_POLARITY)) begin
            polarity_q <= low_bits(reg_wdata);
         end
         if (reg_wr && (reg_addr == `IAEP_REG_DIST_EN)) begin
            dist_en_q <= reg_wdata[NUM_EXT-1:0];
         end
         if (reg_wr && (reg_addr == `IAEP_REG_DIST_SEL0)) begin
            dist_sel_q[NUM_EXT*`IAEP_CHAIN_SEL_W/2-1:0] <= reg_wdata[NUM_EXT*`IAEP_CHAIN_SEL_W/2-1:0];
         end
         if (reg_wr && (reg_addr == `IAEP_REG_DIST_SEL1)) begin
            dist_sel_q[NUM_EXT*`IAEP_CHAIN_SEL_W-1:NUM_EXT*`IAEP_CHAIN_SEL_W/2] <=
               reg_wdata[NUM_EXT*`IAEP_CHAIN_SEL_W/2-1:0];
         end
         request_q <= request_d;
         pending_q <= pending_d;
         // One-cycle delivery pulse to the host, then a gap cycle before the next grant.
         host_irq <= grant_found && !host_irq;
         if (grant_found && !host_irq) begin
            host_irq_line <= grant_idx;
         end
         chain_shared_interrupt_out <= chain_out_d;
         chain_shared_interrupt_oe <= chain_oe_d;
      end
   end

   // ---------------------------------------------------------------
   // Read port
   // ---------------------------------------------------------------
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         reg_rdata <= {`IAEP_DATA_W{1'b0}};
      end else if (reg_rd) begin
         case (reg_addr)
            `IAEP_REG_ARM: reg_rdata <= rd_pad(arm_q);
            `IAEP_REG_ENABLE: reg_rdata <= rd_pad(enable_q);
            `IAEP_REG_PEND_CLR: reg_rdata <= rd_pad(pending_q);
            `IAEP_REG_LEVEL: reg_rdata <= rd_pad(level_q);
            `IAEP_REG_POLARITY: reg_rdata <= rd_pad(polarity_q);
            `IAEP_REG_DIST_EN: reg_rdata <= {{(`IAEP_DATA_W-NUM_EXT){1'b0}}, dist_en_q};
            `IAEP_REG_REQUEST: reg_rdata <= rd_pad(request_q);
            `IAEP_REG_PENDING: reg_rdata <= rd_pad(pending_q);
            `IAEP_REG_STATUS: begin
               reg_rdata <= {{(`IAEP_DATA_W-`IAEP_STAT_VALID_BIT-1){1'b0}}, grant_found,
                  {(`IAEP_STAT_VALID_BIT-`IAEP_LINE_W){1'b0}}, grant_idx};
            end
            `IAEP_REG_DIST_SEL0: begin
               reg_rdata <= {{(`IAEP_DATA_W-NUM_EXT*`IAEP_CHAIN_SEL_W/2){1'b0}},
                  dist_sel_q[NUM_EXT*`IAEP_CHAIN_SEL_W/2-1:0]};
            end
            `IAEP_REG_DIST_SEL1: begin
               reg_rdata <= {{(`IAEP_DATA_W-NUM_EXT*`IAEP_CHAIN_SEL_W/2){1'b0}},
                  dist_sel_q[NUM_EXT*`IAEP_CHAIN_SEL_W-1:NUM_EXT*`IAEP_CHAIN_SEL_W/2]};
            end
            `IAEP_REG_RAW: reg_rdata <= rd_pad(line_level);
            default: reg_rdata <= {`IAEP_DATA_W{1'b0}};
         endcase
      end else begin
         reg_rdata <= {`IAEP_DATA_W{1'b0}};
      end
   end

endmodule

// ===== tb/iaep_properties.sv
`timescale 1ns/1ps
`include "iaep_defines.vh"
module iaep_properties #(
   parameter NUM_EXT = 12,
   parameter NUM_CHAIN = 8
) (
   // Clock and reset
   input wire clock,
   input wire rstn,
   // Register port
   input wire [`IAEP_ADDR_W-1:0] reg_addr,
   input wire [`IAEP_DATA_W-1:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   input wire [`IAEP_DATA_W-1:0] reg_rdata,
   // Interrupt lines
   input wire [NUM_EXT-1:0] ext_irq_in,
   input wire [NUM_CHAIN-1:0] chain_shared_interrupt_in,
   input wire [NUM_CHAIN-1:0] chain_shared_interrupt_out,
   input wire [NUM_CHAIN-1:0] chain_shared_interrupt_oe,
   input wire host_irq,
   input wire [`IAEP_LINE_W-1:0] host_irq_line
);
// Shadow copies of arm, enable and pending kept from the port traffic.
reg [19:0] arm_q, en_q, pnd_q;
wire [19:0] ae = arm_q & en_q;
wire [19:0] clr = (reg_wr && reg_addr == `IAEP_REG_PEND_CLR) ? reg_wdata[19:0] : 20'h0;
wire [19:0] hit = host_irq ? (20'h1 << host_irq_line) : 20'h0;
always @(posedge clock or negedge rstn) begin
   if (!rstn) begin
      arm_q <= 20'h0;
      en_q <= 20'h0;
      pnd_q <= 20'h0;
   end else begin
      if (reg_wr && reg_addr == `IAEP_REG_ARM)
         arm_q <= reg_wdata[19:0];
      if (reg_wr && reg_addr == `IAEP_REG_ENABLE)
         en_q <= reg_wdata[19:0];
      pnd_q <= (pnd_q | hit) & ~clr;
   end
end
default clocking cb @(posedge clock); endclocking
default disable iff (!rstn);
irq_gate_a: assert property (host_irq |-> (($past(ae) >> host_irq_line) & 20'h1) != 0)
   else $error("irq on a line not armed and enabled");
pend_block_a: assert property (host_irq |-> (($past(pnd_q) >> host_irq_line) & 20'h1) == 0)
   else $error("irq on a pending line");
irq_gap_a: assert property (host_irq |=> !host_irq)
   else $error("grants not separated");
line_range_a: assert property (host_irq |-> host_irq_line < 5'h14)
   else $error("irq line out of range");
arm_read_a: assert property (reg_rd && reg_addr == `IAEP_REG_ARM |=> reg_rdata == {12'h0, $past(arm_q)})
   else $error("arm readback wrong");
en_read_a: assert property (reg_rd && reg_addr == `IAEP_REG_ENABLE |=> reg_rdata == {12'h0, $past(en_q)})
   else $error("enable readback wrong");
pend_read_a: assert property (reg_rd && reg_addr == `IAEP_REG_PENDING && !host_irq |=>
   reg_rdata == {12'h0, $past(pnd_q)})
   else $error("pending readback wrong");
chain_drive_a: assert property ((chain_shared_interrupt_out & ~chain_shared_interrupt_oe) == 0)
   else $error("chain level without drive enable");
cover property (host_irq);
cover property (host_irq && host_irq_line == 5'h0C);
cover property (chain_shared_interrupt_oe != 0 && chain_shared_interrupt_out != 0);
endmodule
bind iaep_top iaep_properties #(.NUM_EXT(NUM_EXT), .NUM_CHAIN(NUM_CHAIN)) u_props (.clock(clock), .rstn(rstn),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .ext_irq_in(ext_irq_in), .chain_shared_interrupt_in(chain_shared_interrupt_in),
   .chain_shared_interrupt_out(chain_shared_interrupt_out), .chain_shared_interrupt_oe(chain_shared_interrupt_oe),
   .host_irq(host_irq), .host_irq_line(host_irq_line));

// ===== tb/iaep_peer.sv
`timescale 1ns/1ps
module iaep_peer #(
   parameter HOLD = 30
) (
   // Clock and reset
   input wire clock,
   input wire rstn,
   // Requested levels, external lines low, chain lines high
   input wire [19:0] want,
   // Driven lines
   output reg [11:0] ext_out,
   output reg [7:0] chain_out
);
// A level is held for HOLD+1 cycles before it may change again.
reg [7:0] cnt_q;
always @(posedge clock or negedge rstn) begin
   if (!rstn) begin
      ext_out <= 12'h000;
      chain_out <= 8'h00;
      cnt_q <= 8'h00;
   end else if (cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'h01;
   end else if (want != {chain_out, ext_out}) begin
      {chain_out, ext_out} <= want;
      cnt_q <= HOLD[7:0];
   end
end
endmodule

// ===== tb/iaep_top_tb.sv
`timescale 1ns/1ps
`include "iaep_defines.vh"
module iaep_top_tb;
localparam HOLD = 30;
reg clock, rstn, reg_wr, reg_rd;
reg [3:0] reg_addr;
reg [31:0] reg_wdata;
reg [19:0] want;
wire [31:0] reg_rdata;
wire [11:0] ext;
wire [7:0] chin, chout, choe;
wire host_irq;
wire [4:0] host_irq_line;
reg [9:0] log_q;
reg [67:0] rows [0:8];
integer n_fail, samples_checked, n_irq, i;
iaep_top u_dut (.clock(clock), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_irq_in(ext), .chain_shared_interrupt_in(chin),
   .chain_shared_interrupt_out(chout), .chain_shared_interrupt_oe(choe), .host_irq(host_irq),
   .host_irq_line(host_irq_line));
iaep_peer #(.HOLD(HOLD)) u_peer (.clock(clock), .rstn(rstn), .want(want), .ext_out(ext), .chain_out(chin));
initial begin
   clock = 1'b0;
   forever #25 clock = ~clock;
end
always @(posedge clock) begin
   if (host_irq === 1'b1) begin
      n_irq <= n_irq + 1;
      log_q <= {log_q[4:0], host_irq_line};
   end
end
task chk(input [31:0] s, input [31:0] e);
   begin
      samples_checked = samples_checked + 1;
      if (s !== e) begin
         n_fail = n_fail + 1;
         $display("ERROR t=%0t seen %h expected %h", $time, s, e);
      end
   end
endtask
task idle(input integer n);
   repeat (n) @(posedge clock);
endtask
task wr(input [3:0] a, input [31:0] d);
   begin
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
   end
endtask
task rd(input [3:0] a, input [31:0] e);
   begin
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      @(negedge clock);
      chk(reg_rdata, e);
   end
endtask
task set(input integer n, input v);
   begin
      @(posedge clock);
      want[n] <= v;
      idle(HOLD + 8);
   end
endtask
task do_reset;
   begin
      @(posedge clock);
      rstn <= 1'b0;
      idle(3);
      rstn <= 1'b1;
   end
endtask
task complete_run;
   begin
      $display("checked %0d failed %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   end
endtask
initial begin
   #1000000;
   n_fail = n_fail + 1;
   complete_run;
end
initial begin
   rstn = 1'b0;
   reg_wr = 1'b0;
   reg_rd = 1'b0;
   reg_addr = 4'h0;
   reg_wdata = 32'h0;
   want = 20'h0;
   log_q = 10'h0;
   n_irq = 0;
   n_fail = 0;
   samples_checked = 0;
   rows[0] = {`IAEP_REG_POLARITY, 32'h000F0F0F, 32'h000F0F0F};
   rows[1] = {`IAEP_REG_ENABLE, 32'h000A5A5A, 32'h000A5A5A};
   rows[2] = {`IAEP_REG_LEVEL, 32'h00030000, 32'h00030000};
   rows[3] = {`IAEP_REG_ARM, 32'hFFF5A5A5, 32'h0005A5A5};
   rows[4] = {`IAEP_REG_DIST_EN, 32'hFFFFFFFF, 32'h00000FFF};
   rows[5] = {`IAEP_REG_DIST_SEL0, 32'h2AAAAAAA, 32'h0002AAAA};
   rows[6] = {`IAEP_REG_DIST_SEL1, 32'h00015555, 32'h00015555};
   rows[7] = {`IAEP_REG_REQUEST, 32'h000FFFFF, 32'h0};
   rows[8] = {4'hC, 32'h00000001, 32'h0};
   do_reset;
   for (i = 0; i < 16; i = i + 1)
      rd(i[3:0], (i == 4) ? 32'h000FFFFF : 32'h0);
   $display("reset values done");
   for (i = 0; i < 9; i = i + 1) begin
      wr(rows[i][67:64], rows[i][63:32]);
      rd(rows[i][67:64], rows[i][31:0]);
   end
   $display("register rows done");
   // ---------------------------------------------------------------
   // Hand-written cases
   // ---------------------------------------------------------------
   do_reset;
   set(0, 1'b1);
   set(0, 1'b0);
   chk(n_irq, 0);
   wr(`IAEP_REG_ARM, 32'h1);
   set(0, 1'b1);
   set(0, 1'b0);
   chk(n_irq, 0);
   rd(`IAEP_REG_REQUEST, 32'h1);
   wr(`IAEP_REG_ENABLE, 32'h1);
   idle(4);
   chk(n_irq, 1);
   rd(`IAEP_REG_REQUEST, 32'h0);
   rd(`IAEP_REG_PENDING, 32'h1);
   set(0, 1'b0);
   set(0, 1'b1);
   chk(n_irq, 1);
   wr(`IAEP_REG_PEND_CLR, 32'h1);
   idle(4);
   chk(n_irq, 2);
   wr(`IAEP_REG_PEND_CLR, 32'h1);
   idle(HOLD);
   chk(n_irq, 2);
   set(0, 1'b0);
   set(0, 1'b1);
   chk(n_irq, 3);
   $display("edge and pending done");
   wr(`IAEP_REG_ARM, 32'h3);
   set(1, 1'b1);
   set(1, 1'b0);
   rd(`IAEP_REG_REQUEST, 32'h2);
   wr(`IAEP_REG_ARM, 32'h1);
   rd(`IAEP_REG_REQUEST, 32'h0);
   set(1, 1'b1);
   set(1, 1'b0);
   rd(`IAEP_REG_REQUEST, 32'h0);
   wr(`IAEP_REG_ARM, 32'h28);
   set(3, 1'b1);
   set(5, 1'b1);
   wr(`IAEP_REG_ENABLE, 32'h28);
   idle(6);
   chk(n_irq, 5);
   chk(log_q, {5'h03, 5'h05});
   $display("disarm and priority done");
   wr(`IAEP_REG_POLARITY, 32'hFFFFB);
   wr(`IAEP_REG_ARM, 32'h4);
   wr(`IAEP_REG_ENABLE, 32'h4);
   set(2, 1'b1);
   chk(n_irq, 5);
   set(2, 1'b0);
   chk(n_irq, 6);
   wr(`IAEP_REG_LEVEL, 32'h10);
   wr(`IAEP_REG_ARM, 32'h10);
   wr(`IAEP_REG_ENABLE, 32'h10);
   set(4, 1'b1);
   chk(n_irq, 7);
   wr(`IAEP_REG_PEND_CLR, 32'h10);
   idle(4);
   chk(n_irq, 8);
   wr(`IAEP_REG_ARM, 32'h0);
   wr(`IAEP_REG_LEVEL, 32'h40);
   wr(`IAEP_REG_POLARITY, 32'hFFFBF);
   wr(`IAEP_REG_ARM, 32'h40);
   wr(`IAEP_REG_ENABLE, 32'h40);
   idle(8);
   chk(n_irq, 9);
   wr(`IAEP_REG_ARM, 32'h0);
   $display("modes done");
   wr(`IAEP_REG_DIST_EN, 32'h80);
   wr(`IAEP_REG_DIST_SEL1, 32'h10);
   set(7, 1'b1);
   chk(chout, 32'h4);
   chk(choe, 32'h4);
   rd(`IAEP_REG_RAW, 32'h000000B9);
   chk(n_irq, 9);
   set(7, 1'b0);
   chk(chout, 32'h0);
   wr(`IAEP_REG_ARM, 32'h1000);
   wr(`IAEP_REG_ENABLE, 32'h1000);
   set(12, 1'b1);
   chk(n_irq, 10);
   chk(log_q[4:0], 32'h0C);
   $display("chain done");
   complete_run;
end
endmodule
